// *** src/mir_pkg.sv ***
package mir_pkg;
	// Register byte offsets
	localparam logic [4:0] ADR_INTC     = 5'h00;
	localparam logic [4:0] ADR_FIFO_REQ = 5'h04;
	localparam logic [4:0] ADR_USB_CS   = 5'h08;
	localparam logic [4:0] ADR_STATUS   = 5'h0c;
	localparam logic [4:0] ADR_CONFIG   = 5'h10;
	// Interrupt control fields
	localparam int INTC_GIE    = 0;
	localparam int INTC_EN_USB = 1;
	localparam int INTC_EN_T0  = 2;
	localparam int INTC_EN_T1  = 3;
	localparam int INTC_F_USB  = 4;
	localparam int INTC_F_T0   = 5;
	localparam int INTC_F_T1   = 6;
	// USB control/status, status and config fields
	localparam int USB_CS_SUSPEND = 0;
	localparam int USB_CS_RESUME  = 3;
	localparam int STAT_TIMEOUT   = 0;
	localparam int STAT_STACK     = 1;
	localparam int STAT_PDOWN     = 2;
	localparam int CFG_PIN_RST    = 0;
	localparam int CFG_LVR        = 1;
	localparam int FIFO_NUM       = 3;
	// Reset values
	localparam logic [7:0] INTC_RST   = 8'h00;
	localparam logic [7:0] USB_CS_RST = 8'h00;
	localparam logic [1:0] CONFIG_RST = 2'h3;
	localparam logic [7:0] PORT_RST   = 8'hff;
	// Vectors
	localparam logic [11:0] VEC_USB = 12'h004;
	localparam logic [11:0] VEC_T0  = 12'h008;
	localparam logic [11:0] VEC_T1  = 12'h00c;
	// Timing
	localparam int CLK_PERIOD_NS         = 20;
	localparam int RESET_DELAY_TIME_NS   = 1000;
	localparam int LOW_SUPPLY_QUALIFY_NS = 1000;
	localparam logic [11:0] RESET_DELAY_CYC =
		12'((RESET_DELAY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [11:0] LOW_SUPPLY_CYC =
		12'((LOW_SUPPLY_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_HOLD  = 2'b01,
		ST_DELAY = 2'b10
	} mir_state_t;

	typedef struct packed {
		mir_state_t          state;
		logic [11:0]         dly_cnt;
		logic [11:0]         lv_cnt;
		logic [7:0]          intc;
		logic [FIFO_NUM-1:0] fifo_req;
		logic [7:0]          usb_cs;
		logic                timeout_flag;
		logic [1:0]          config_opt;
		logic                ack;
		logic [7:0]          rdata;
		logic                call;
		logic [11:0]         vector;
		logic                pc_sp_clear;
	} mir_regs_t;
endpackage

// *** src/mir_irq_reset_ctrl.sv ***
// Operation
// - Timer interrupt needs global and own enable
// - Timer overflow always sets its request flag
// - Timer call to vector 08H or 0CH
// - Timer service clears its flag and global enable
// - Flag stays until serviced or software cleared
// - Any interrupt source wakes from power-down
// - Entry pushes only the program counter
// - FIFO access, suspend, resume, bus reset set USB flag
// - USB call to 04H clears flag and global
// - FIFO access sets its bit; firmware clears
// - Bus suspend sets control bit 0, interrupts
// - Bus resume sets control bit 3, interrupts
// - Program counter zero after power-on delay
// - Power-on sets port registers to ones
// - Reset pin low clears PC, restarts on release
// - Extra reset delay after release before fetch
// - Pin acts as reset only when configured
// - Low-voltage reset only after qualifying time
// - Watchdog normal time-out resets, sets flag
// - Watchdog power-down time-out clears PC, SP only
// - Priority USB, then timer 0, then timer 1
// - Full stack defers service; nesting via enable
// - Requests serviced on next T2 pulse
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mir_irq_reset_ctrl
	import mir_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [4:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	// Event sources
	input  wire logic                timer0_ovf_i,
	input  wire logic                timer1_ovf_i,
	input  wire logic [FIFO_NUM-1:0] usb_fifo_access_i,
	input  wire logic                usb_suspend_i,
	input  wire logic                usb_resume_i,
	input  wire logic                usb_bus_reset_i,
	// Core status
	input  wire logic                t2_pulse_i,
	input  wire logic                stack_full_i,
	input  wire logic                power_down_i,
	// Reset sources
	input  wire logic                port_a_bit7_i,
	input  wire logic                low_supply_i,
	input  wire logic                watchdog_timeout_i,
	// Core control
	output logic                     irq_call_o,
	output logic      [11:0]         irq_vector_o,
	output logic                     wake_o,
	output logic                     core_reset_o,
	output logic                     pc_sp_clear_o,
	output logic                     port_preset_o,
	output logic      [7:0]          port_preset_value_o
);
	mir_regs_t r_reg;
	mir_regs_t r_next;

	logic       wr_en;
	logic [7:0] wd;
	logic       pin_rst;
	logic       lv_rst;
	logic       wdt_run;
	logic       wdt_pd;
	logic       src;
	logic       run;
	logic [2:0] pend;
	logic       usb_evt;

	function automatic logic [7:0] rd_mux(input mir_regs_t s, input logic [4:0] a,
			input logic sf, input logic pd);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADR_INTC:     v = s.intc;
			ADR_FIFO_REQ: v[FIFO_NUM-1:0] = s.fifo_req;
			ADR_USB_CS:   v = s.usb_cs;
			ADR_STATUS: begin
				v[STAT_TIMEOUT] = s.timeout_flag;
				v[STAT_STACK]   = sf;
				v[STAT_PDOWN]   = pd;
			end
			ADR_CONFIG:   v[1:0] = s.config_opt;
			default:      v = 8'h00;
		endcase
		return v;
	endfunction

	assign run     = (r_reg.state == ST_RUN);
	assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && r_reg.ack && wb_sel_i[0];
	assign wd      = wb_dat_i[7:0];
	assign pin_rst = r_reg.config_opt[CFG_PIN_RST] && !port_a_bit7_i;
	assign lv_rst  = r_reg.config_opt[CFG_LVR] && low_supply_i
		&& (r_reg.lv_cnt == LOW_SUPPLY_CYC);
	assign wdt_run = watchdog_timeout_i && !power_down_i;
	assign wdt_pd  = watchdog_timeout_i && power_down_i;
	assign src     = pin_rst || lv_rst || wdt_run;
	assign usb_evt = (|usb_fifo_access_i) || usb_suspend_i || usb_resume_i
		|| usb_bus_reset_i;
	// Enabled requests; global enable is checked at service
	assign pend[0] = r_reg.intc[INTC_F_USB] && r_reg.intc[INTC_EN_USB];
	assign pend[1] = r_reg.intc[INTC_F_T0] && r_reg.intc[INTC_EN_T0];
	assign pend[2] = r_reg.intc[INTC_F_T1] && r_reg.intc[INTC_EN_T1];

	always_comb begin
		r_next = r_reg;
		r_next.call = 1'b0;
		r_next.pc_sp_clear = 1'b0;
		// Wishbone: ack one cycle after request, write at the ack edge
		r_next.ack = wb_cyc_i && wb_stb_i && !r_reg.ack;
		r_next.rdata = rd_mux(r_reg, wb_adr_i, stack_full_i, power_down_i);
		if (r_reg.config_opt[CFG_LVR] && low_supply_i) begin
			if (r_reg.lv_cnt != LOW_SUPPLY_CYC)
				r_next.lv_cnt = r_reg.lv_cnt + 12'h001;
		end else begin
			r_next.lv_cnt = 12'h000;
		end
		if (wr_en) begin
			case (wb_adr_i)
				ADR_INTC:     r_next.intc = {1'b0, wd[6:0]};
				ADR_FIFO_REQ: r_next.fifo_req = wd[FIFO_NUM-1:0];
				ADR_USB_CS:   r_next.usb_cs = wd;
				ADR_CONFIG:   r_next.config_opt = wd[1:0];
				default:      r_next.intc = r_next.intc;
			endcase
		end
		// Service on T2 pulse in fixed priority
		if (run && t2_pulse_i && r_reg.intc[INTC_GIE] && !stack_full_i
				&& (|pend)) begin
			r_next.call = 1'b1;
			r_next.intc[INTC_GIE] = 1'b0;
			if (pend[0]) begin
				r_next.vector = VEC_USB;
				r_next.intc[INTC_F_USB] = 1'b0;
			end else if (pend[1]) begin
				r_next.vector = VEC_T0;
				r_next.intc[INTC_F_T0] = 1'b0;
			end else begin
				r_next.vector = VEC_T1;
				r_next.intc[INTC_F_T1] = 1'b0;
			end
		end
		// Events applied after writes and service so they beat those clears
		if (timer0_ovf_i)
			r_next.intc[INTC_F_T0] = 1'b1;
		if (timer1_ovf_i)
			r_next.intc[INTC_F_T1] = 1'b1;
		if (usb_evt)
			r_next.intc[INTC_F_USB] = 1'b1;
		r_next.fifo_req = r_next.fifo_req | usb_fifo_access_i;
		if (usb_suspend_i)
			r_next.usb_cs[USB_CS_SUSPEND] = 1'b1;
		if (usb_resume_i)
			r_next.usb_cs[USB_CS_RESUME] = 1'b1;
		// Watchdog flag
		if (watchdog_timeout_i)
			r_next.timeout_flag = 1'b1;
		else if (pin_rst || lv_rst)
			r_next.timeout_flag = 1'b0;
		if (wdt_pd)
			r_next.pc_sp_clear = 1'b1;
		// Reset sequencer
		case (r_reg.state)
			ST_RUN: begin
				if (src)
					r_next.state = ST_HOLD;
			end
			ST_HOLD: begin
				r_next.dly_cnt = 12'h000;
				if (!src)
					r_next.state = ST_DELAY;
			end
			ST_DELAY: begin
				r_next.dly_cnt = r_reg.dly_cnt + 12'h001;
				if (src)
					r_next.state = ST_HOLD;
				else if (r_reg.dly_cnt == RESET_DELAY_CYC - 12'h001)
					r_next.state = ST_RUN;
			end
			default: r_next.state = ST_HOLD;
		endcase
		// Full reset clears interrupt state
		if (r_next.state == ST_HOLD) begin
			r_next.intc = INTC_RST;
			r_next.fifo_req = '0;
			r_next.usb_cs = USB_CS_RST;
			r_next.call = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg.state <= ST_DELAY;
			r_reg.dly_cnt <= 12'h000;
			r_reg.lv_cnt <= 12'h000;
			r_reg.intc <= INTC_RST;
			r_reg.fifo_req <= '0;
			r_reg.usb_cs <= USB_CS_RST;
			r_reg.timeout_flag <= 1'b0;
			r_reg.config_opt <= CONFIG_RST;
			r_reg.ack <= 1'b0;
			r_reg.rdata <= 8'h00;
			r_reg.call <= 1'b0;
			r_reg.vector <= 12'h000;
			r_reg.pc_sp_clear <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign wb_ack_o            = r_reg.ack;
	assign wb_dat_o            = {24'h000000, r_reg.rdata};
	assign irq_call_o          = r_reg.call;
	assign irq_vector_o        = r_reg.vector;
	assign core_reset_o        = !run;
	assign pc_sp_clear_o       = r_reg.pc_sp_clear || !run;
	assign port_preset_o       = !run;
	assign port_preset_value_o = PORT_RST;
	// Any latched source, enabled or not
	assign wake_o = power_down_i && ((|r_reg.intc[6:4]) || watchdog_timeout_i);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_CALL_GATED: assert property (irq_call_o |-> $past(r_reg.intc[INTC_GIE])
		&& $past(t2_pulse_i) && !$past(stack_full_i))
		else $error("Call taken without enable, T2 or stack room");
	AST_T0_SETS: assert property (run && timer0_ovf_i && !src
		|=> r_reg.intc[INTC_F_T0])
		else $error("Timer 0 overflow did not set its flag");
	AST_USB_FIRST: assert property (irq_call_o && $past(pend[0])
		|-> irq_vector_o == VEC_USB)
		else $error("USB request not serviced first");
	AST_T1_VEC: assert property (irq_call_o && $past(pend) == 3'b100
		|-> irq_vector_o == VEC_T1 && !r_reg.intc[INTC_GIE])
		else $error("Timer 1 vector or global clear wrong");
	AST_FLAG_HOLDS: assert property (run && !src && r_reg.intc[INTC_F_T1]
		&& !wr_en && !(t2_pulse_i && r_reg.intc[INTC_GIE])
		|=> r_reg.intc[INTC_F_T1])
		else $error("Timer 1 flag dropped without cause");
	AST_WAKE: assert property (power_down_i && r_reg.intc[INTC_F_USB]
		|-> wake_o)
		else $error("Pending USB flag did not wake core");
	AST_SUSPEND: assert property (run && !src && usb_suspend_i
		|=> r_reg.usb_cs[USB_CS_SUSPEND] && r_reg.intc[INTC_F_USB])
		else $error("Suspend not recorded");
	AST_RESUME: assert property (run && !src && usb_resume_i
		|=> r_reg.usb_cs[USB_CS_RESUME] && r_reg.intc[INTC_F_USB])
		else $error("Resume not recorded");
	AST_DELAY: assert property (r_reg.state == ST_HOLD && !src
		|=> core_reset_o [*8])
		else $error("Reset released without delay");
	AST_WDT_PD: assert property (run && wdt_pd && !pin_rst && !lv_rst
		|=> pc_sp_clear_o && r_reg.timeout_flag && !core_reset_o)
		else $error("Power-down time-out handled wrongly");
	AST_WDT_RUN: assert property (run && wdt_run
		|=> core_reset_o && r_reg.timeout_flag)
		else $error("Normal time-out did not reset");
	AST_PIN_OFF: assert property (run && !r_reg.config_opt[CFG_PIN_RST]
		&& !lv_rst && !wdt_run |=> !core_reset_o)
		else $error("Reset without an enabled source");
endmodule
`default_nettype wire

// *** sim/mir_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mir_core_model #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Stack traffic
	input  wire logic call_i,
	input  wire logic pop_i,
	// Core status
	output logic      t2_pulse_o,
	output logic      stack_full_o
);
	logic [1:0] ph_reg;
	int         depth_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_reg <= 2'h0;
			depth_reg <= 0;
		end else begin
			ph_reg <= ph_reg + 2'h1;
			// Entry pushes one word, the program counter
			depth_reg <= depth_reg + int'(call_i) - int'(pop_i && depth_reg > 0);
		end
	end
	assign t2_pulse_o   = (ph_reg == 2'h3);
	assign stack_full_o = (depth_reg >= DEPTH);
endmodule
`default_nettype wire

// *** sim/mir_irq_reset_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module mir_irq_reset_ctrl_bench import mir_pkg::*; ;
	logic        clk_i, rst_i, cyc, stb, we, ack, call, wake, crst, pcsp, pre;
	logic        t2, sf, ps, wdt, pa7, pop, lv;
	logic [3:0]  sel;
	logic [4:0]  adr;
	logic [7:0]  wd, ev, q, pval;
	logic [11:0] vec;
	logic [31:0] dat_o;
	int          n_fail, comparisons, n_calls;
	mir_irq_reset_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i({24'h0, wd}),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .timer0_ovf_i(ev[1]), .timer1_ovf_i(ev[0]),
		.usb_fifo_access_i(ev[7:5]), .usb_suspend_i(ev[4]), .usb_resume_i(ev[3]),
		.usb_bus_reset_i(ev[2]), .t2_pulse_i(t2), .stack_full_i(sf), .power_down_i(ps),
		.port_a_bit7_i(pa7), .low_supply_i(lv), .watchdog_timeout_i(wdt),
		.irq_call_o(call), .irq_vector_o(vec), .wake_o(wake), .core_reset_o(crst),
		.pc_sp_clear_o(pcsp), .port_preset_o(pre), .port_preset_value_o(pval));
	mir_core_model #(.DEPTH(1)) core (.clk_i(clk_i), .rst_i(rst_i), .call_i(call),
		.pop_i(pop), .t2_pulse_o(t2), .stack_full_o(sf));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (call === 1'b1) n_calls++;
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d;
		do begin @(posedge clk_i); #1; end while (ack !== 1'b1);
		q = dat_o[7:0];
		@(posedge clk_i);
		cyc <= 1'b0; stb <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e, input string m);
		wb(1'b0, a, 8'h00);
		chk({4'h0, q}, {4'h0, e}, m);
	endtask
	task automatic pulse(input logic [7:0] e);
		@(posedge clk_i); ev <= e;
		@(posedge clk_i); ev <= 8'h00;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_call(input logic [11:0] v);
		int n0;
		n0 = n_calls;
		for (int i = 0; i < 20 && n_calls == n0; i++) tick(1);
		chk(12'(n_calls - n0), 12'h1, "call count");
		chk(vec, v, "vector");
	endtask
	task automatic t_reset();
		tick(49);
		chk({9'h0, crst, pcsp, pre}, 12'h7, "held after release");
		chk({4'h0, pval}, {4'h0, PORT_RST}, "port preset");
		tick(4);
		chk({11'h0, crst}, 12'h0, "reset end");
		$display("test reset done");
	endtask
	task automatic t_timer();
		wb(1'b1, ADR_INTC, 8'h05);
		pulse(8'h02);
		wait_call(VEC_T0);
		rd(ADR_INTC, 8'h04, "timer0 entry");
		wb(1'b1, ADR_INTC, 8'h09);
		pulse(8'h01);
		tick(12);
		rd(ADR_INTC, 8'h49, "deferred while full");
		@(posedge clk_i); pop <= 1'b1;
		@(posedge clk_i); pop <= 1'b0;
		wait_call(VEC_T1);
		rd(ADR_INTC, 8'h08, "timer1 entry");
		@(posedge clk_i); pop <= 1'b1;
		@(posedge clk_i); pop <= 1'b0;
		$display("test timer done");
	endtask
	task automatic t_usb();
		wb(1'b1, ADR_INTC, 8'h07);
		pulse(8'h32);
		wait_call(VEC_USB);
		rd(ADR_INTC, 8'h26, "usb entry");
		rd(ADR_USB_CS, 8'h01, "suspend");
		rd(ADR_FIFO_REQ, 8'h01, "fifo bit");
		wb(1'b1, ADR_USB_CS, 8'h00);
		pulse(8'h08);
		rd(ADR_USB_CS, 8'h08, "resume");
		rd(ADR_INTC, 8'h36, "usb flag again");
		$display("test usb done");
	endtask
	task automatic t_wake();
		@(posedge clk_i); ps <= 1'b1; pop <= 1'b1;
		@(posedge clk_i); pop <= 1'b0;
		tick(1);
		chk({11'h0, wake}, 12'h1, "wake");
		wb(1'b1, ADR_INTC, 8'h00);
		pulse(8'h01);
		rd(ADR_INTC, 8'h40, "flag when disabled");
		@(posedge clk_i); wdt <= 1'b1;
		@(posedge clk_i); wdt <= 1'b0;
		#1;
		chk({10'h0, crst, pcsp}, 12'h1, "pd timeout");
		tick(1);
		chk({11'h0, pcsp}, 12'h0, "pd pulse ends");
		rd(ADR_STATUS, 8'h05, "pd status");
		@(posedge clk_i); ps <= 1'b0;
		$display("test wake done");
	endtask
	task automatic t_pin();
		@(posedge clk_i); pa7 <= 1'b0;
		tick(3);
		chk({11'h0, crst}, 12'h1, "pin reset");
		@(posedge clk_i); pa7 <= 1'b1;
		tick(56);
		chk({11'h0, crst}, 12'h0, "pin restart");
		rd(ADR_STATUS, 8'h00, "pin clears flag");
		rd(ADR_INTC, 8'h00, "intc cleared");
		@(posedge clk_i); wdt <= 1'b1;
		@(posedge clk_i); wdt <= 1'b0;
		tick(3);
		chk({11'h0, crst}, 12'h1, "watchdog reset");
		tick(56);
		rd(ADR_STATUS, 8'h01, "watchdog flag");
		$display("test pin done");
	endtask
	task automatic low_supply_qualify_time();
		@(posedge clk_i); lv <= 1'b1;
		tick(30);
		@(posedge clk_i); lv <= 1'b0;
		tick(3);
		chk({11'h0, crst}, 12'h0, "short low supply ignored");
		@(posedge clk_i); lv <= 1'b1;
		tick(55);
		chk({11'h0, crst}, 12'h1, "low supply reset");
		@(posedge clk_i); lv <= 1'b0;
		tick(56);
		chk({11'h0, crst}, 12'h0, "low supply restart");
		rd(ADR_STATUS, 8'h00, "low supply clears flag");
		@(posedge clk_i); sel <= 4'h0;
		wb(1'b1, ADR_CONFIG, 8'h00);
		@(posedge clk_i); sel <= 4'h1;
		rd(ADR_CONFIG, 8'h03, "write without sel ignored");
		wb(1'b1, ADR_CONFIG, 8'h00);
		@(posedge clk_i); pa7 <= 1'b0;
		tick(4);
		chk({11'h0, crst}, 12'h0, "pin reset disabled");
		@(posedge clk_i); pa7 <= 1'b1;
		$display("test lvr done");
	endtask
	initial begin
		{cyc, stb, we, ps, wdt, pop} = '0;
		{adr, wd, ev} = '0;
		pa7 = 1'b1;
		lv = 1'b0;
		sel = 4'h1;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_timer();
		t_usb();
		t_wake();
		t_pin();
		low_supply_qualify_time();
		give_verdict();
	end
	initial begin
		#100us;
		n_fail++;
		give_verdict();
	end
endmodule
`default_nettype wire
